//--- rtl/dsc_pkg.sv
// Package with register map, field positions and reset values of the gating bank
package dsc_pkg;
   // ------------------------------------------------------------
   // Register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [11:0] OFS_RUN_GATE = 12'h100;
   localparam logic [11:0] OFS_SLEEP_GATE = 12'h110;
   localparam logic [11:0] OFS_DEEP_GATE = 12'h120;
   localparam logic [11:0] OFS_AUTO_CTRL = 12'h130;
   localparam logic [31:0] SYSCTL_BASE = 32'h400FE000;

   // ------------------------------------------------------------
   // Field positions and masks
   // ------------------------------------------------------------
   localparam int NUM_UNITS = 4;
   localparam int BIT_WATCHDOG = 3;
   localparam int BIT_HIBERNATION = 6;
   localparam int BIT_ADC0 = 16;
   localparam int BIT_PWM = 20;
   localparam int BIT_AUTO_GATE = 0;
   localparam logic [31:0] GATE_WR_MASK = 32'h00110048;
   localparam logic [31:0] AUTO_WR_MASK = 32'h00000001;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [31:0] RUN_GATE_RST = 32'h00000040;
   localparam logic [31:0] SLEEP_GATE_RST = 32'h00000040;
   localparam logic [31:0] DEEP_GATE_RST = 32'h00000040;
   localparam logic [31:0] AUTO_CTRL_RST = 32'h00000000;

   // ------------------------------------------------------------
   // Avalon response codes
   // ------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECODE_ERR = 2'h3;

   typedef enum logic [1:0] {PM_RUN, PM_SLEEP, PM_DEEP} dsc_pm_e;
endpackage

//--- rtl/dsc_gate_bank.sv
// Clock gating bank for peripheral group 0 with Avalon-MM register slave
`timescale 1ns/1ns

// Notes on behaviour
// - each writable gating-register bit enables one unit's clock
// - access to unclocked unit returns bus fault
// - deep-sleep register resets to 0x00000040
// - bit 6 gates hibernation, resets set
// - bit 20 gates pwm, resets clear
// - bit 16 gates adc0, resets clear
// - bit 3 gates watchdog, resets clear
// - other bits read zero, writes ignored
// - run, sleep, deep copies; deep governs deep-sleep only with auto gating
// - sleep copies apply only with auto gating
// - deep-sleep register at offset 0x120
module dsc_gate_bank #(
   parameter int ADDR_W = 12
) (
   input wire logic sys_clk, // System clock, 10 MHz
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic [ADDR_W-1:0] avs_address, // Byte address
   input wire logic avs_read, // Read request
   input wire logic avs_write, // Write request
   input wire logic [31:0] avs_writedata, // Write data
   input wire logic [3:0] avs_byteenable, // Write byte lanes
   output logic [31:0] avs_readdata, // Read data
   output logic avs_waitrequest, // Stall until answer
   output logic [1:0] avs_response, // Access result
   input wire logic sleep_mode, // System in sleep
   input wire logic deep_sleep_mode, // System in deep-sleep
   input wire logic [dsc_pkg::NUM_UNITS-1:0] periph_access, // Access aimed at unit
   output logic [dsc_pkg::NUM_UNITS-1:0] periph_fault, // Bus fault for unit
   output logic [dsc_pkg::NUM_UNITS-1:0] unit_clk_en, // Registered clock enable
   output logic [dsc_pkg::NUM_UNITS-1:0] unit_gclk // Gated unit clocks
);
   import dsc_pkg::*;

   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   if (ADDR_W < 9 || ADDR_W > 12) begin : g_chk
      $error("dsc_gate_bank: ADDR_W must be 9 to 12");
   end

   localparam int UNIT_BIT [NUM_UNITS] = '{BIT_WATCHDOG, BIT_HIBERNATION, BIT_ADC0, BIT_PWM};

   function automatic logic [NUM_UNITS-1:0] pick_units(input logic [31:0] reg_val);
      logic [NUM_UNITS-1:0] res;
      res = '0;
      for (int i = 0; i < NUM_UNITS; i++) begin
         res[i] = reg_val[UNIT_BIT[i]];
      end
      return res;
   endfunction

   function automatic logic [31:0] merge_wr(input logic [31:0] old_val,
                                            input logic [31:0] wdata,
                                            input logic [3:0] be,
                                            input logic [31:0] mask);
      logic [31:0] lanes;
      lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      return ((old_val & ~lanes) | (wdata & lanes)) & mask;
   endfunction

   // ------------------------------------------------------------
   // Bus handshake
   // ------------------------------------------------------------
   logic ack_q;
   logic [11:0] addr;
   logic hit_run, hit_sleep, hit_deep, hit_auto, hit_any;
   logic wr_go;

   assign addr = 12'(avs_address);
   assign hit_run = (addr == OFS_RUN_GATE);
   assign hit_sleep = (addr == OFS_SLEEP_GATE);
   assign hit_deep = (addr == OFS_DEEP_GATE);
   assign hit_auto = (addr == OFS_AUTO_CTRL);
   assign hit_any = hit_run | hit_sleep | hit_deep | hit_auto;
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   assign wr_go = avs_write & ack_q;

   always_ff @(posedge sys_clk) begin
      if (sys_rst || ack_q) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= avs_read | avs_write;
      end
   end

   // ------------------------------------------------------------
   // Gating registers
   // ------------------------------------------------------------
   logic [31:0] run_gate_q, sleep_gate_q, deep_gate_q, auto_ctrl_q;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         run_gate_q <= RUN_GATE_RST;
      end else if (wr_go && hit_run) begin
         run_gate_q <= merge_wr(run_gate_q, avs_writedata, avs_byteenable, GATE_WR_MASK);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         sleep_gate_q <= SLEEP_GATE_RST;
      end else if (wr_go && hit_sleep) begin
         sleep_gate_q <= merge_wr(sleep_gate_q, avs_writedata, avs_byteenable, GATE_WR_MASK);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         deep_gate_q <= DEEP_GATE_RST;
      end else if (wr_go && hit_deep) begin
         // Only bits 3, 6, 16 and 20 are writable
         deep_gate_q <= merge_wr(deep_gate_q, avs_writedata, avs_byteenable,
                                 GATE_WR_MASK);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         auto_ctrl_q <= AUTO_CTRL_RST;
      end else if (wr_go && hit_auto) begin
         auto_ctrl_q <= merge_wr(auto_ctrl_q, avs_writedata, avs_byteenable, AUTO_WR_MASK);
      end
   end

   // ------------------------------------------------------------
   // Read data and response
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         avs_readdata <= 32'h00000000;
         avs_response <= RESP_OKAY;
      end else if ((avs_read | avs_write) && !ack_q) begin
         avs_response <= hit_any ? RESP_OKAY : RESP_DECODE_ERR;
         if (!avs_read) begin
            avs_readdata <= 32'h00000000;
         end else if (hit_run) begin
            avs_readdata <= run_gate_q;
         end else if (hit_sleep) begin
            avs_readdata <= sleep_gate_q;
         end else if (hit_deep) begin
            avs_readdata <= deep_gate_q;
         end else if (hit_auto) begin
            avs_readdata <= auto_ctrl_q;
         end else begin
            avs_readdata <= 32'h00000000;
         end
      end
   end

   // ------------------------------------------------------------
   // Power mode and effective enables
   // ------------------------------------------------------------
   dsc_pm_e mode_q;
   logic auto_gate;
   logic [NUM_UNITS-1:0] sel_en;

   assign auto_gate = auto_ctrl_q[BIT_AUTO_GATE];

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         mode_q <= PM_RUN;
      end else if (deep_sleep_mode) begin
         mode_q <= PM_DEEP;
      end else if (sleep_mode) begin
         mode_q <= PM_SLEEP;
      end else begin
         mode_q <= PM_RUN;
      end
   end

   always_comb begin
      sel_en = pick_units(run_gate_q);
      case (mode_q)
         PM_RUN: sel_en = pick_units(run_gate_q);
         PM_SLEEP: begin
            if (auto_gate) begin
               sel_en = pick_units(sleep_gate_q);
            end
         end
         PM_DEEP: begin
            if (auto_gate) begin
               sel_en = pick_units(deep_gate_q);
            end
         end
         default: sel_en = pick_units(run_gate_q);
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         unit_clk_en <= pick_units(RUN_GATE_RST);
      end else begin
         unit_clk_en <= sel_en;
      end
   end

   // ------------------------------------------------------------
   // Glitch-free clock gates and bus faults
   // ------------------------------------------------------------
   logic [NUM_UNITS-1:0] en_lat;

   for (genvar g = 0; g < NUM_UNITS; g++) begin : g_icg
      // Enable may only change while the clock is low
      always_latch begin
         if (!sys_clk) begin
            en_lat[g] = unit_clk_en[g];
         end
      end
      assign unit_gclk[g] = sys_clk & en_lat[g];
   end

   assign periph_fault = periph_access & ~unit_clk_en;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   sequence s_req_start;
      (avs_read | avs_write) && !ack_q;
   endsequence

   sequence s_answer;
      !avs_waitrequest && ack_q;
   endsequence

   AST_ANSWER_ONE: assert property (@(posedge sys_clk) disable iff (sys_rst)
      s_req_start |=> s_answer)
      else $error("bus answer not one cycle after request");

   AST_READ_DEEP: assert property (@(posedge sys_clk) disable iff (sys_rst)
      s_req_start ##0 (avs_read && addr == OFS_DEEP_GATE) |=> (avs_readdata == deep_gate_q))
      else $error("deep-sleep register read data wrong");

   AST_RESET_VAL: assert property (@(posedge sys_clk)
      sys_rst |=> (deep_gate_q == 32'h00000040))
      else $error("deep-sleep register reset value wrong");

   AST_HIB_DEFAULT: assert property (@(posedge sys_clk)
      sys_rst ##1 !sys_rst |=> unit_clk_en[1])
      else $error("hibernation clock not on after reset");

   AST_RSVD_ZERO: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (deep_gate_q & ~GATE_WR_MASK) == 32'h00000000)
      else $error("reserved deep-sleep bit set");

   AST_WRITE_DEEP: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (wr_go && hit_deep && avs_byteenable == 4'hF)
      |=> (deep_gate_q == ($past(avs_writedata) & 32'h00110048)))
      else $error("deep-sleep register write wrong");

   AST_DEEP_GOV: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (mode_q == PM_DEEP && auto_gate) |=> (unit_clk_en == {$past(deep_gate_q[20]),
      $past(deep_gate_q[16]), $past(deep_gate_q[6]), $past(deep_gate_q[3])}))
      else $error("deep-sleep enables not from deep register");

   AST_NO_AUTO: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (!auto_gate && mode_q != PM_RUN) |=> (unit_clk_en == {$past(run_gate_q[20]),
      $past(run_gate_q[16]), $past(run_gate_q[6]), $past(run_gate_q[3])}))
      else $error("run register not used without auto gating");

   AST_FAULT: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (mode_q == PM_DEEP && auto_gate && !deep_gate_q[BIT_WATCHDOG]) ##1 periph_access[0]
      |-> periph_fault[0])
      else $error("no bus fault for unclocked watchdog");
endmodule

//--- testbench/dsc_periph_model.sv
// Model of the gated peripherals: counts the clock edges that each unit receives
`timescale 1ns/1ns
module dsc_periph_model #(
   parameter int HALF_NS = 50
) (
   input wire logic edge_clr, // Zero all edge counts
   input wire logic [3:0] unit_gclk, // Gated unit clocks
   output logic [3:0][15:0] edge_cnt, // Rising edges seen per unit
   output logic [3:0] short_pulse // Sticky: a high pulse of wrong width was seen
);
   // ------------------------------------------------------------
   // One edge counter per unit; a missing or extra pulse shows up in the count
   // ------------------------------------------------------------
   for (genvar i = 0; i < 4; i++) begin : g_unit
      always @(posedge unit_gclk[i] or posedge edge_clr) begin
         if (edge_clr) edge_cnt[i] <= 16'h0;
         else edge_cnt[i] <= edge_cnt[i] + 16'h1;
      end
      // Every high pulse must last a full half period, also across enable changes
      realtime t_rise;
      bit seen_rise;
      initial short_pulse[i] = 1'b0;
      always @(posedge unit_gclk[i]) begin
         t_rise = $realtime;
         seen_rise = 1'b1;
      end
      always @(negedge unit_gclk[i]) begin
         if (seen_rise && ($realtime - t_rise) != HALF_NS) short_pulse[i] = 1'b1;
      end
   end
endmodule

//--- testbench/tb_top.sv
// Self-checking testbench for the deep-sleep clock gating bank
`timescale 1ns/1ns
module tb_top;
   import dsc_pkg::*;
   logic sys_clk, sys_rst, avs_read, avs_write, avs_waitrequest, sleep_mode, deep_sleep_mode;
   logic edge_clr;
   logic [11:0] avs_address, a;
   logic [31:0] avs_writedata, avs_readdata, rd, w;
   logic [3:0] avs_byteenable, periph_access, periph_fault, unit_clk_en, unit_gclk, short_pulse;
   logic [1:0] avs_response, rsp;
   logic [3:0][15:0] edge_cnt;
   logic [31:0] m_reg [4];
   int fail_count, total_checks, cycles, seed;
   localparam logic [11:0] OFS [4] = '{OFS_RUN_GATE, OFS_SLEEP_GATE, OFS_DEEP_GATE, OFS_AUTO_CTRL};

   dsc_gate_bank u_dsc_gate_bank (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .avs_response(avs_response), .sleep_mode(sleep_mode), .deep_sleep_mode(deep_sleep_mode),
      .periph_access(periph_access), .periph_fault(periph_fault),
      .unit_clk_en(unit_clk_en), .unit_gclk(unit_gclk));
   dsc_periph_model u_dsc_periph_model (.edge_clr(edge_clr), .unit_gclk(unit_gclk),
      .edge_cnt(edge_cnt), .short_pulse(short_pulse));

   // ------------------------------------------------------------
   // Clock, timeout, reporting
   // ------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles > 5000) begin
         fail_count++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // ------------------------------------------------------------
   // Reference model and bus tasks
   // ------------------------------------------------------------
   function automatic int reg_idx(input logic [11:0] ad);
      reg_idx = -1;
      for (int i = 0; i < 4; i++) if (ad == OFS[i]) reg_idx = i;
   endfunction
   function automatic logic [3:0] exp_en(input logic slp, input logic dp);
      logic [31:0] s;
      s = m_reg[0];
      if (m_reg[3][BIT_AUTO_GATE] && dp) s = m_reg[2];
      else if (m_reg[3][BIT_AUTO_GATE] && slp) s = m_reg[1];
      exp_en = {s[BIT_PWM], s[BIT_ADC0], s[BIT_HIBERNATION], s[BIT_WATCHDOG]};
   endfunction
   task automatic bus(input logic wr, input logic [11:0] ad, input logic [31:0] d,
                      input logic [3:0] be);
      int k;
      logic [31:0] msk;
      @(posedge sys_clk);
      avs_address <= ad;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge sys_clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      rsp = avs_response;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      k = reg_idx(ad);
      for (int b = 0; b < 4; b++) msk[b*8 +: 8] = {8{be[b]}};
      msk &= (k == 3) ? AUTO_WR_MASK : GATE_WR_MASK;
      if (wr && k >= 0) m_reg[k] = (m_reg[k] & ~msk) | (d & msk);
   endtask
   task automatic rd_chk(input logic [11:0] ad);
      int k;
      k = reg_idx(ad);
      bus(1'b0, ad, 32'h0, 4'hF);
      chk("readdata", rd, (k < 0) ? 32'h0 : m_reg[k]);
      chk("response", {30'h0, rsp}, {30'h0, (k < 0) ? RESP_DECODE_ERR : RESP_OKAY});
   endtask
   task automatic en_chk(input logic slp, input logic dp);
      logic [3:0] e;
      e = exp_en(slp, dp);
      @(posedge sys_clk);
      sleep_mode <= slp;
      deep_sleep_mode <= dp;
      periph_access <= 4'($random(seed));
      repeat (3) @(posedge sys_clk);
      edge_clr <= 1'b1;
      @(posedge sys_clk);
      edge_clr <= 1'b0;
      repeat (16) @(posedge sys_clk);
      #1;
      chk("unit_clk_en", {28'h0, unit_clk_en}, {28'h0, e});
      chk("periph_fault", {28'h0, periph_fault}, {28'h0, periph_access & ~e});
      for (int i = 0; i < 4; i++) begin
         chk("gclk_edges", {16'h0, edge_cnt[i]}, e[i] ? 32'h10 : 32'h0);
      end
      chk("gclk_pulse", {28'h0, short_pulse}, 32'h0);
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      seed = 38;
      sys_rst = 1'b1;
      {avs_read, avs_write, sleep_mode, deep_sleep_mode, edge_clr} = 5'h0;
      avs_address = 12'h0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h0;
      periph_access = 4'h0;
      m_reg = '{RUN_GATE_RST, SLEEP_GATE_RST, DEEP_GATE_RST, AUTO_CTRL_RST};
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      for (int k = 0; k < 4; k++) rd_chk(OFS[k]);
      rd_chk(12'h124);
      en_chk(1'b0, 1'b1);
      $display("test reset values done");
      for (int n = 0; n < 24; n++) begin
         w = $random(seed);
         a = (n % 6 == 5) ? 12'h12C : OFS[n % 4];
         bus(1'b1, a, w, 4'($random(seed)));
         rd_chk(a);
      end
      $display("test register access done");
      for (int n = 0; n < 16; n++) begin
         for (int k = 0; k < 3; k++) bus(1'b1, OFS[k], $random(seed), 4'hF);
         bus(1'b1, OFS_AUTO_CTRL, {31'h0, n[2]}, 4'hF);
         en_chk(n[0], n[1]);
      end
      $display("test mode gating done");
      @(posedge sys_clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      m_reg = '{RUN_GATE_RST, SLEEP_GATE_RST, DEEP_GATE_RST, AUTO_CTRL_RST};
      for (int k = 0; k < 4; k++) rd_chk(OFS[k]);
      en_chk(1'b0, 1'b0);
      $display("test mid-run reset done");
      report_and_stop();
   end
endmodule
